/* inc/icrc_consts.vh */
`ifndef ICRC_CONSTS_VH
`define ICRC_CONSTS_VH
`define ICRC_POLY 16'h8005
`define ICRC_BITS_PER_BYTE 4'h8
`define ICRC_PC_BACKUP 16'h0003
`define ICRC_ZERO16 16'h0000
`define ICRC_ONE16 16'h0001
`define ICRC_MSB 15
`define ICRC_SHIFT_ZERO 4'h0
`define ICRC_SHIFT_ONE 4'h1
`endif

/* verification/icrc_engine_asserts.sv */
`timescale 1ns/1ns
`include "icrc_consts.vh"
module icrc_engine_asserts(input wire core_clk, sys_rst, start,
  input wire [15:0] operandAddr, operandCount, pcIn, byteCounter, arrayPointer, memReadAddr,
  input wire [15:0] polynomialHolder, pcOut,
  input wire busy, incompleteFlag, memReadReq, done, yielded, instrFetchReq,
  input wire interruptSeqReq, interruptSeqDone);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_fresh;
    start && !busy && !incompleteFlag;
  endsequence
  property p_load;
    s_fresh ##0 operandCount != 16'h0000 |=> memReadReq && memReadAddr == $past(operandAddr);
  endproperty
  a_load: assert property (p_load) else $error("first read address wrong");
  property p_flag;
    memReadReq |-> incompleteFlag;
  endproperty
  a_flag: assert property (p_flag) else $error("flag clear during read");
  property p_empty;
    s_fresh ##0 operandCount == 16'h0000 |-> ##2 done && instrFetchReq && pcOut == $past(pcIn, 2) + 16'h0001;
  endproperty
  a_empty: assert property (p_empty) else $error("empty array finish wrong");
  property p_pulse;
    done |=> !done;
  endproperty
  a_pulse: assert property (p_pulse) else $error("done too long");
  property p_clear;
    done && !yielded |-> !incompleteFlag && byteCounter == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("finish state wrong");
  property p_yield;
    yielded |-> done && incompleteFlag && polynomialHolder == `ICRC_POLY;
  endproperty
  a_yield: assert property (p_yield) else $error("yield state wrong");
  property p_hold;
    interruptSeqReq && !interruptSeqDone |=> interruptSeqReq;
  endproperty
  a_hold: assert property (p_hold) else $error("sequence request dropped");
  property p_dec;
    busy && $past(busy) && byteCounter != $past(byteCounter) |-> byteCounter == $past(byteCounter) - 16'h0001;
  endproperty
  a_dec: assert property (p_dec) else $error("count step wrong");
  property p_addr;
    memReadReq |-> memReadAddr == arrayPointer;
  endproperty
  a_addr: assert property (p_addr) else $error("read address not pointer");
endmodule
bind icrc_engine icrc_engine_asserts u_icrc_engine_asserts(.*);

/* verification/icrc_engine_tb.sv */
`timescale 1ns/1ns
module icrc_engine_tb;
  reg core_clk = 0, sys_rst = 1, start = 0, accLoad = 0, incompleteIn = 0, flagLoad = 0;
  reg interruptPending = 0;
  reg [15:0] operandAddr = 0, operandCount = 0, pcIn = 0, accIn = 0;
  wire [15:0] memReadData, memReadAddr, crcAccumulator, arrayPointer, byteCounter;
  wire [15:0] polynomialHolder, pcOut;
  wire memoryReadComplete, interruptSeqDone, memReadReq, incompleteFlag, instrFetchReq;
  wire interruptSeqReq, busy, done, yielded;
  integer num_errors = 0, checks = 0;
  icrc_engine u_icrc_engine(.*);
  icrc_mem_model u_icrc_mem_model(.*);
  initial forever #10 core_clk = ~core_clk;
  function [15:0] crcRef(input [15:0] r, input [15:0] a, input integer c);
    integer i, b;
    reg [15:0] w;
    for (i = 0; i < c; i = i + 1) begin
      w = a + i / 2;
      w = {w[7:0], ~w[7:0] ^ 8'h3C};
      for (b = 0; b < 8; b = b + 1) r = {r[14:0], w[15 - 8 * (i % 2) - b]} ^ (r[15] ? 16'h8005 : 16'h0000);
    end
    crcRef = r;
  endfunction
  task chk(input [15:0] s, e);
    checks = checks + 1;
    if (s !== e) begin
      num_errors = num_errors + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task end_sim;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Accumulator and flag loads are skipped on a resume so the saved state survives.
  task run(input [15:0] a, c, p, acc, input ld, ip);
    integer n;
    @(posedge core_clk) #2;
    {operandAddr, operandCount, pcIn, accIn, accLoad, flagLoad, interruptPending} = {a, c, p, acc, ld, ld, ip};
    @(posedge core_clk) #2;
    {accLoad, flagLoad, start} = 3'h1;
    @(posedge core_clk) #2;
    start = 0;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge core_clk) #1;
      n = n + 1;
    end
    if (n == 3000) begin
      num_errors = num_errors + 1;
      end_sim;
    end
    chk({15'h0, busy}, 16'h0000);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    #2 sys_rst = 0;
    run(16'h0040, 16'h0003, 16'h0100, 16'h0000, 1, 0);
    chk(crcAccumulator, crcRef(16'h0000, 16'h0040, 3));
    chk(pcOut, 16'h0101);
    chk({15'h0, instrFetchReq}, 16'h0001);
    chk(polynomialHolder, 16'h8005);
    run(16'h0080, 16'h0004, 16'h0200, 16'h1234, 1, 0);
    chk(crcAccumulator, crcRef(16'h1234, 16'h0080, 4));
    run(16'h0090, 16'h0000, 16'h0300, 16'h5A5A, 1, 0);
    chk(crcAccumulator, 16'h5A5A);
    run(16'h00A0, 16'h0006, 16'h0400, 16'h0000, 1, 1);
    chk({14'h0, yielded, incompleteFlag}, 16'h0003);
    chk(pcOut, 16'h03FD);
    chk(arrayPointer, 16'h00A1);
    chk(byteCounter, 16'h0004);
    chk(crcAccumulator, crcRef(16'h0000, 16'h00A0, 2));
    run(16'h0FFF, 16'h0009, 16'h0400, 16'h0000, 0, 0);
    chk(crcAccumulator, crcRef(16'h0000, 16'h00A0, 6));
    chk(pcOut, 16'h0401);
    run(16'h00C0, 16'h0002, 16'h0500, 16'h0000, 1, 1);
    chk({14'h0, yielded, incompleteFlag}, 16'h0000);
    chk(crcAccumulator, crcRef(16'h0000, 16'h00C0, 2));
    end_sim;
  end
endmodule

/* verification/icrc_mem_model.sv */
`timescale 1ns/1ns
module icrc_mem_model(input wire core_clk, input wire memReadReq, input wire [15:0] memReadAddr,
  output reg [15:0] memReadData, output reg memoryReadComplete,
  input wire interruptSeqReq, output reg interruptSeqDone);
  reg [15:0] a = 16'h0000;
  reg slow = 1'b0;
  integer w = 0;
  initial begin
    memReadData = 16'h0000;
    memoryReadComplete = 1'b0;
    interruptSeqDone = 1'b0;
  end
  // Reads alternate prompt and slow; the bus shows junk outside a completion.
  always @(posedge core_clk) begin
    memoryReadComplete <= 1'b0;
    interruptSeqDone <= 1'b0;
    memReadData <= ~memReadData;
    if (memReadReq) begin
      a <= memReadAddr;
      w <= slow ? 4 : 1;
      slow <= ~slow;
    end else if (w == 1) begin
      memReadData <= {a[7:0], ~a[7:0] ^ 8'h3C};
      memoryReadComplete <= 1'b1;
      w <= 0;
    end else if (w > 1) begin
      w <= w - 1;
    end
    if (interruptSeqReq && !interruptSeqDone) begin
      interruptSeqDone <= 1'b1;
    end
  end
endmodule

/* verilog/icrc_bit_step.v */
`timescale 1ns/1ns
`include "icrc_consts.vh"
module icrc_bit_step (
  input wire [15:0] remIn,
  input wire dataBit,
  output wire [15:0] remOut,
  output wire msbOut
);
  assign msbOut = remIn[`ICRC_MSB];
  assign remOut = {remIn[`ICRC_MSB - 1:0], dataBit} ^ (msbOut ? `ICRC_POLY : `ICRC_ZERO16);
endmodule

/* verilog/icrc_engine.v */
`timescale 1ns/1ns
`include "icrc_consts.vh"
module icrc_engine (
  input wire core_clk,
  input wire sys_rst,
  input wire start,
  input wire [15:0] operandAddr,
  input wire [15:0] operandCount,
  input wire [15:0] pcIn,
  input wire [15:0] accIn,
  input wire accLoad,
  input wire incompleteIn,
  input wire flagLoad,
  input wire [15:0] memReadData,
  input wire memoryReadComplete,
  input wire interruptPending,
  input wire interruptSeqDone,
  output reg memReadReq,
  output reg [15:0] memReadAddr,
  output reg [15:0] crcAccumulator,
  output reg [15:0] arrayPointer,
  output reg [15:0] byteCounter,
  output reg [15:0] polynomialHolder,
  output reg incompleteFlag,
  output reg [15:0] pcOut,
  output reg instrFetchReq,
  output reg interruptSeqReq,
  output reg busy,
  output reg done,
  output reg yielded
);
  // ----------------------------------------
  // State encoding
  // ----------------------------------------
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_WAIT = 4'h1;
  localparam [3:0] ST_SHIFT = 4'h2;
  localparam [3:0] ST_BYTEEND = 4'h3;
  localparam [3:0] ST_INTCHK = 4'h4;
  localparam [3:0] ST_INTSEQ = 4'h5;
  localparam [3:0] ST_FINISH = 4'h6;

  reg [3:0] state_reg;
  reg [15:0] operandShiftRegister_reg;
  reg [3:0] shiftCount_reg;
  reg rightByte_reg;
  reg shiftedOutFlag_reg;
  reg intSample_reg;
  reg [3:0] state_next;
  reg [15:0] operandShiftRegister_next;
  reg [3:0] shiftCount_next;
  reg rightByte_next;
  reg shiftedOutFlag_next;
  reg intSample_next;
  reg memReadReq_next;
  reg [15:0] memReadAddr_next;
  reg [15:0] crcAccumulator_next;
  reg [15:0] arrayPointer_next;
  reg [15:0] byteCounter_next;
  reg [15:0] polynomialHolder_next;
  reg incompleteFlag_next;
  reg [15:0] pcOut_next;
  reg instrFetchReq_next;
  reg interruptSeqReq_next;
  reg busy_next;
  reg done_next;
  reg yielded_next;
  wire [15:0] stepRem;
  wire stepMsb;
  wire [15:0] cntDec;

  assign cntDec = byteCounter - `ICRC_ONE16;

  icrc_bit_step bitStep (
    .remIn(crcAccumulator),
    .dataBit(operandShiftRegister_reg[`ICRC_MSB]),
    .remOut(stepRem),
    .msbOut(stepMsb)
  );

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // The xor with the polynomial is applied only when the old bit 15 is set, which saves
  // the separate correction cycle that an always-xor datapath would need.
  always @* begin
    state_next = state_reg;
    operandShiftRegister_next = operandShiftRegister_reg;
    shiftCount_next = shiftCount_reg;
    rightByte_next = rightByte_reg;
    shiftedOutFlag_next = shiftedOutFlag_reg;
    intSample_next = intSample_reg;
    memReadReq_next = 1'b0;
    memReadAddr_next = memReadAddr;
    crcAccumulator_next = crcAccumulator;
    arrayPointer_next = arrayPointer;
    byteCounter_next = byteCounter;
    polynomialHolder_next = polynomialHolder;
    incompleteFlag_next = incompleteFlag;
    pcOut_next = pcOut;
    instrFetchReq_next = 1'b0;
    interruptSeqReq_next = interruptSeqReq;
    busy_next = busy;
    done_next = 1'b0;
    yielded_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (accLoad) begin
          crcAccumulator_next = accIn;
        end
        if (flagLoad) begin
          incompleteFlag_next = incompleteIn;
        end
        if (start) begin
          busy_next = 1'b1;
          polynomialHolder_next = `ICRC_POLY;
          pcOut_next = pcIn;
          rightByte_next = 1'b0;
          shiftCount_next = `ICRC_BITS_PER_BYTE;
          if (incompleteFlag) begin
            memReadReq_next = 1'b1;
            memReadAddr_next = arrayPointer;
            state_next = ST_WAIT;
          end else if (operandCount == `ICRC_ZERO16) begin
            arrayPointer_next = operandAddr;
            byteCounter_next = operandCount;
            state_next = ST_FINISH;
          end else begin
            arrayPointer_next = operandAddr;
            byteCounter_next = operandCount;
            memReadReq_next = 1'b1;
            memReadAddr_next = operandAddr;
            incompleteFlag_next = 1'b1;
            state_next = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        // Read data is taken only in the completion cycle; at other times the memory
        // bus carries nothing usable.
        // wait for memory
        if (memoryReadComplete) begin
          operandShiftRegister_next = memReadData;
          shiftCount_next = `ICRC_BITS_PER_BYTE;
          rightByte_next = 1'b0;
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        crcAccumulator_next = stepRem;
        shiftedOutFlag_next = stepMsb;
        operandShiftRegister_next = {operandShiftRegister_reg[`ICRC_MSB - 1:0], 1'b0};
        shiftCount_next = shiftCount_reg - `ICRC_SHIFT_ONE;
        if (shiftCount_reg == `ICRC_SHIFT_ONE) begin
          state_next = ST_BYTEEND;
        end
      end
      ST_BYTEEND: begin
        byteCounter_next = cntDec;
        if (!rightByte_reg) begin
          if (cntDec == `ICRC_ZERO16) begin
            state_next = ST_FINISH;
          end else begin
            rightByte_next = 1'b1;
            shiftCount_next = `ICRC_BITS_PER_BYTE;
            state_next = ST_SHIFT;
          end
        end else begin
          intSample_next = interruptPending;
          state_next = ST_INTCHK;
        end
      end
      ST_INTCHK: begin
        intSample_next = 1'b0;
        // A request seen at byte end must still stand one cycle later, since a trap
        // taken in between withdraws it.
        // second sample confirms
        if (intSample_reg && interruptPending) begin
          if (byteCounter == `ICRC_ZERO16) begin
            arrayPointer_next = arrayPointer + `ICRC_ONE16;
            state_next = ST_FINISH;
          end else begin
            arrayPointer_next = arrayPointer + `ICRC_ONE16;
            pcOut_next = pcOut - `ICRC_PC_BACKUP;
            interruptSeqReq_next = 1'b1;
            state_next = ST_INTSEQ;
          end
        end else if (byteCounter == `ICRC_ZERO16) begin
          state_next = ST_FINISH;
        end else begin
          arrayPointer_next = arrayPointer + `ICRC_ONE16;
          memReadReq_next = 1'b1;
          memReadAddr_next = arrayPointer + `ICRC_ONE16;
          state_next = ST_WAIT;
        end
      end
      ST_INTSEQ: begin
        if (interruptSeqDone) begin
          interruptSeqReq_next = 1'b0;
          busy_next = 1'b0;
          yielded_next = 1'b1;
          done_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_FINISH: begin
        incompleteFlag_next = 1'b0;
        pcOut_next = pcOut + `ICRC_ONE16;
        instrFetchReq_next = 1'b1;
        busy_next = 1'b0;
        done_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      operandShiftRegister_reg <= `ICRC_ZERO16;
      shiftCount_reg <= `ICRC_SHIFT_ZERO;
      rightByte_reg <= 1'b0;
      shiftedOutFlag_reg <= 1'b0;
      intSample_reg <= 1'b0;
      memReadReq <= 1'b0;
      memReadAddr <= `ICRC_ZERO16;
      crcAccumulator <= `ICRC_ZERO16;
      arrayPointer <= `ICRC_ZERO16;
      byteCounter <= `ICRC_ZERO16;
      polynomialHolder <= `ICRC_ZERO16;
      incompleteFlag <= 1'b0;
      pcOut <= `ICRC_ZERO16;
      instrFetchReq <= 1'b0;
      interruptSeqReq <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      yielded <= 1'b0;
    end else begin
      state_reg <= state_next;
      operandShiftRegister_reg <= operandShiftRegister_next;
      shiftCount_reg <= shiftCount_next;
      rightByte_reg <= rightByte_next;
      shiftedOutFlag_reg <= shiftedOutFlag_next;
      intSample_reg <= intSample_next;
      memReadReq <= memReadReq_next;
      memReadAddr <= memReadAddr_next;
      crcAccumulator <= crcAccumulator_next;
      arrayPointer <= arrayPointer_next;
      byteCounter <= byteCounter_next;
      polynomialHolder <= polynomialHolder_next;
      incompleteFlag <= incompleteFlag_next;
      pcOut <= pcOut_next;
      instrFetchReq <= instrFetchReq_next;
      interruptSeqReq <= interruptSeqReq_next;
      busy <= busy_next;
      done <= done_next;
      yielded <= yielded_next;
    end
  end
endmodule
